// File: shared/media_fmt_pkg.sv
// shared constants for the media format and security receive block
package media_fmt_pkg;
    // ========================================
    // register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;    // write: opcode, issues a command
    localparam logic [7:0] OFF_CDW10 = 8'h04;  // command dword ten
    localparam logic [7:0] OFF_CDW11 = 8'h08;  // command dword eleven
    localparam logic [7:0] OFF_STATUS = 8'h0C; // read: live state
    localparam logic [7:0] OFF_CPL = 8'h10;    // read: completion, write: pop
    localparam logic [7:0] OFF_FMT = 8'h14;    // read: applied format
    localparam logic [7:0] OFF_CTRL = 8'h18;   // lock level, reset and link-loss pulses
    localparam logic [7:0] OFF_FMT_TABLE = 8'h1C; // block format table port
    localparam logic [7:0] OFF_RDATA = 8'h20;  // read: security receive data
    // ========================================
    // command opcodes
    localparam logic [7:0] OP_FORMAT = 8'h80;
    localparam logic [7:0] OP_SEC_SEND = 8'h81;
    localparam logic [7:0] OP_SEC_RECV = 8'h82;
    // ========================================
    // dword ten fields
    localparam int PROT_FIRST_BIT = 8;
    localparam int PROT_TYPE_LSB = 5;
    localparam int INLINE_BIT = 4;
    localparam int FMT_INDEX_LSB = 0;
    localparam int SECP_LSB = 24;
    localparam logic [2:0] PROT_NONE = 3'h0;
    localparam logic [2:0] PROT_RSVD_MIN = 3'h4;
    localparam logic [7:0] PROT_BYTES = 8'h08;
    // ========================================
    // register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CPL_BIT = 1;
    localparam int STAT_SEC_BIT = 2;
    localparam int STAT_LOCK_BIT = 3;
    localparam int CPL_OP_LSB = 8;
    localparam int CPL_VALID_BIT = 16;
    localparam int FMT_INLINE_BIT = 3;
    localparam int FMT_IDX_LSB = 4;
    localparam int FMT_FIRST_BIT = 8;
    localparam int FMT_OFF_LSB = 16;
    localparam int CTRL_LOCK_BIT = 0;
    localparam int CTRL_RST_BIT = 1;
    localparam int CTRL_LOST_BIT = 2;
    localparam int TABLE_SUP_BIT = 4;
    localparam int TABLE_MD_LSB = 8;
    // ========================================
    // status codes and security protocols
    localparam logic [7:0] SC_SUCCESS = 8'h00;
    localparam logic [7:0] SC_INVALID_OPCODE = 8'h01;
    localparam logic [7:0] SC_INVALID_FIELD = 8'h02;
    localparam logic [7:0] SC_INVALID_FORMAT = 8'h0A;
    localparam logic [7:0] SECP_DISCOVERY = 8'h00;
    localparam logic [7:0] SECP_DEVICE = 8'hEA;
    localparam logic [31:0] SEC_DISC_WORD = 32'h0000_01EA;
    // ========================================
    // reset values and timing
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam int FORMAT_TIME_NS = 160;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FORMAT_CYCLES = (FORMAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : media_fmt_pkg

// File: core/format_engine.sv
// format engine: checks a format request, runs it, applies the new layout
`timescale 1ns/1ps
`default_nettype none
module format_engine (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [31:0] cdw10,
    input wire logic [7:0] md_size,
    input wire logic fmt_supported,
    input wire logic sec_locked,
    output logic busy,
    output logic done_q,
    output logic [7:0] status_q,
    output logic [2:0] prot_type_q,
    output logic inline_q,
    output logic [3:0] index_q,
    output logic prot_first_q,
    output logic [7:0] prot_offset_q
);
    // ========================================
    // state and captured request
    typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_RUN} fmt_state_t;
    localparam int GOOD_LAT = media_fmt_pkg::FORMAT_CYCLES + 2; // start to done
    localparam int RUN_GAP = GOOD_LAT - 8; // after the eight quiet cycles
    fmt_state_t state_q;
    logic [2:0] req_prot_q;    // requested protection type
    logic req_inline_q;        // requested inline metadata
    logic [3:0] req_idx_q;     // requested format index
    logic req_first_q;         // requested protection location
    logic [7:0] req_md_q;      // metadata size of the chosen format
    logic req_ok_q;            // format supported and not locked
    logic [7:0] cnt_q;         // media run countdown
    logic bad;

    assign busy = (state_q != ST_IDLE);

    // reserved type, missing format, lock, or too little metadata
    assign bad = (req_prot_q >= media_fmt_pkg::PROT_RSVD_MIN) || !req_ok_q
        || ((req_prot_q != media_fmt_pkg::PROT_NONE)
            && (req_md_q < media_fmt_pkg::PROT_BYTES));

    // ========================================
    // capture the request so table edits mid-run cannot change it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_prot_q <= 3'h0;
            req_inline_q <= 1'b0;
            req_idx_q <= 4'h0;
            req_first_q <= 1'b0;
            req_md_q <= 8'h00;
            req_ok_q <= 1'b0;
        end else if (start && !busy) begin
            req_prot_q <= cdw10[media_fmt_pkg::PROT_TYPE_LSB +: 3];
            req_inline_q <= cdw10[media_fmt_pkg::INLINE_BIT];
            req_idx_q <= cdw10[media_fmt_pkg::FMT_INDEX_LSB +: 4];
            req_first_q <= cdw10[media_fmt_pkg::PROT_FIRST_BIT];
            req_md_q <= md_size;
            req_ok_q <= fmt_supported && !sec_locked;
        end
    end

    // ========================================
    // sequencer; a good format is done only once the media run is over, a refused one straight from the check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            done_q <= 1'b0;
            status_q <= media_fmt_pkg::SC_SUCCESS;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (bad) begin
                        // refused up front, media untouched
                        status_q <= media_fmt_pkg::SC_INVALID_FORMAT;
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= 8'(media_fmt_pkg::FORMAT_CYCLES - 1);
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (cnt_q == 8'h00) begin
                        status_q <= media_fmt_pkg::SC_SUCCESS;
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ========================================
    // applied layout, updated at the end of a good run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot_type_q <= 3'h0;
            inline_q <= 1'b0;
            index_q <= 4'h0;
            prot_first_q <= 1'b0;
            prot_offset_q <= 8'h00;
        end else if (state_q == ST_RUN && cnt_q == 8'h00) begin
            prot_type_q <= req_prot_q;
            index_q <= req_idx_q;
            // no metadata: the placement bit means nothing
            inline_q <= req_inline_q && (req_md_q != 8'h00);
            prot_first_q <= req_first_q;
            // protection in first or last eight metadata bytes
            if (req_prot_q == media_fmt_pkg::PROT_NONE || req_first_q) begin
                prot_offset_q <= 8'h00;
            end else begin
                prot_offset_q <= req_md_q - media_fmt_pkg::PROT_BYTES;
            end
        end
    end

    // ========================================
    // checks
    sequence s_start_bad;
        start && !busy
            && ((cdw10[media_fmt_pkg::PROT_TYPE_LSB +: 3] >= media_fmt_pkg::PROT_RSVD_MIN)
            || !fmt_supported || sec_locked);
    endsequence
    sequence s_start_good;
        start && !busy && fmt_supported && !sec_locked
            && (cdw10[media_fmt_pkg::PROT_TYPE_LSB +: 3] == media_fmt_pkg::PROT_NONE);
    endsequence
    property p_bad_refused;
        @(posedge pclk) disable iff (!presetn)
        s_start_bad |-> ##2 (done_q && status_q == media_fmt_pkg::SC_INVALID_FORMAT);
    endproperty
    a_bad_refused: assert property (p_bad_refused) else $error("bad format not refused");
    property p_good_late;
        @(posedge pclk) disable iff (!presetn)
        s_start_good |-> ##1 (!done_q)[*8] ##RUN_GAP (done_q && status_q == 8'h00);
    endproperty
    a_good_late: assert property (p_good_late) else $error("format done at wrong time");
    property p_md_zero;
        @(posedge pclk) disable iff (!presetn)
        $rose(done_q) && status_q == 8'h00 && req_md_q == 8'h00 |-> !inline_q;
    endproperty
    a_md_zero: assert property (p_md_zero) else $error("inline set without metadata");
    property p_pi_last;
        @(posedge pclk) disable iff (!presetn)
        done_q && status_q == 8'h00 && prot_type_q != 3'h0 && !prot_first_q
            |-> prot_offset_q == req_md_q - 8'h08;
    endproperty
    a_pi_last: assert property (p_pi_last) else $error("protection offset wrong");
endmodule : format_engine
`default_nettype wire

// File: core/media_format_sec_rx.sv
// media format and security receive command block with an apb register port
//
// Contract
// - decode protection type: 1,2,3 on; 4+ reserved
// - placement bit set means inline extended block
// - placement bit ignored with zero metadata
// - low four bits pick the block format
// - format completion posts after media done
// - invalid format status for four failures
// - receive returns earlier send results by protocol
// - pending receive data may drop on reset
// - receive uses only pointers, dwords ten, eleven
// - protection in first or last eight bytes
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module media_format_sec_rx (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ========================================
    // declarations
    localparam int NUM_FMT = 16;      // block formats the table holds
    logic wr_en;                      // write access phase
    logic rd_setup;                   // read setup phase, data latched here
    logic hit;                        // address is mapped
    logic [31:0] cdw10_q;             // command dword ten
    logic [31:0] cdw11_q;             // command dword eleven
    logic sec_locked_q;               // security state forbids format
    logic [3:0] table_sel_q;          // table entry shown on read
    logic fmt_sup_q [NUM_FMT];        // format supported flags
    logic [7:0] fmt_md_q [NUM_FMT];   // metadata bytes per format
    logic cmd_go;                     // accepted command write
    logic [7:0] cmd_op;               // its opcode
    logic fmt_start_q;                // pulse into the engine
    logic fmt_busy;
    logic fmt_done;
    logic [7:0] fmt_status;
    logic [2:0] prot_type;
    logic inline_on;
    logic [3:0] fmt_index;
    logic prot_first;
    logic [7:0] prot_offset;
    logic cpl_valid_q;                // completion entry waiting
    logic [7:0] cpl_status_q;
    logic [7:0] cpl_op_q;
    logic sec_valid_q;                // send result waiting to be read
    logic [7:0] sec_proto_q;          // protocol it belongs to
    logic [31:0] sec_data_q;
    logic [31:0] sec_rdata_q;         // last receive payload
    logic sec_drop;                   // reset or link loss
    logic [7:0] secp;                 // protocol field of dword ten
    logic [31:0] prdata_q;
    logic [31:0] rd_d;

    // ========================================
    // apb decode; zero wait states, pready always high
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign secp = cdw10_q[media_fmt_pkg::SECP_LSB +: 8];
    always_comb begin
        case (paddr)
            media_fmt_pkg::OFF_CMD, media_fmt_pkg::OFF_CDW10, media_fmt_pkg::OFF_CDW11,
            media_fmt_pkg::OFF_STATUS, media_fmt_pkg::OFF_CPL, media_fmt_pkg::OFF_FMT,
            media_fmt_pkg::OFF_CTRL, media_fmt_pkg::OFF_FMT_TABLE,
            media_fmt_pkg::OFF_RDATA: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    // unmapped addresses answer with an error, no state changes
    assign pslverr = psel && penable && !hit;

    // a command is only taken while nothing is outstanding; others are dropped
    assign cmd_go = wr_en && (paddr == media_fmt_pkg::OFF_CMD) && !fmt_busy
        && !cpl_valid_q && !fmt_start_q;
    assign cmd_op = pwdata[7:0];
    assign sec_drop = wr_en && (paddr == media_fmt_pkg::OFF_CTRL)
        && (pwdata[media_fmt_pkg::CTRL_RST_BIT] || pwdata[media_fmt_pkg::CTRL_LOST_BIT]);

    // ========================================
    // command dwords and control levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cdw10_q <= media_fmt_pkg::RST_WORD;
            cdw11_q <= media_fmt_pkg::RST_WORD;
            sec_locked_q <= 1'b0;
            table_sel_q <= 4'h0;
        end else if (wr_en) begin
            // dwords ten and eleven are stored whole; ctrl keeps only the lock level; a table port write also sets the read select to the entry it writes
            if (paddr == media_fmt_pkg::OFF_CDW10) begin
                cdw10_q <= pwdata;
            end
            if (paddr == media_fmt_pkg::OFF_CDW11) begin
                cdw11_q <= pwdata;
            end
            if (paddr == media_fmt_pkg::OFF_CTRL) begin
                sec_locked_q <= pwdata[media_fmt_pkg::CTRL_LOCK_BIT];
            end
            if (paddr == media_fmt_pkg::OFF_FMT_TABLE) begin
                table_sel_q <= pwdata[3:0];
            end
        end
    end

    // ========================================
    // block format table, one entry per generate step; entry 0 is valid at reset
    for (genvar g = 0; g < NUM_FMT; g++) begin : g_fmt
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                fmt_sup_q[g] <= (g == 0);
                fmt_md_q[g] <= 8'h00;
            end else if (wr_en && paddr == media_fmt_pkg::OFF_FMT_TABLE
                         && pwdata[3:0] == 4'(g)) begin
                fmt_sup_q[g] <= pwdata[media_fmt_pkg::TABLE_SUP_BIT];
                fmt_md_q[g] <= pwdata[media_fmt_pkg::TABLE_MD_LSB +: 8];
            end
        end
    end

    // ========================================
    // format start pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_start_q <= 1'b0;
        end else begin
            fmt_start_q <= cmd_go && (cmd_op == media_fmt_pkg::OP_FORMAT);
        end
    end

    // the index field selects the table entry handed to the engine
    format_engine u_engine (
        .pclk(pclk),
        .presetn(presetn),
        .start(fmt_start_q),
        .cdw10(cdw10_q),
        .md_size(fmt_md_q[cdw10_q[media_fmt_pkg::FMT_INDEX_LSB +: 4]]),
        .fmt_supported(fmt_sup_q[cdw10_q[media_fmt_pkg::FMT_INDEX_LSB +: 4]]),
        .sec_locked(sec_locked_q),
        .busy(fmt_busy),
        .done_q(fmt_done),
        .status_q(fmt_status),
        .prot_type_q(prot_type),
        .inline_q(inline_on),
        .index_q(fmt_index),
        .prot_first_q(prot_first),
        .prot_offset_q(prot_offset)
    );

    // ========================================
    // security result slot; a receive of its protocol pops it, a reset or link loss drops it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_valid_q <= 1'b0;
            sec_proto_q <= 8'h00;
            sec_data_q <= media_fmt_pkg::RST_WORD;
            sec_rdata_q <= media_fmt_pkg::RST_WORD;
        end else if (sec_drop) begin
            sec_valid_q <= 1'b0;
        end else if (cmd_go && cmd_op == media_fmt_pkg::OP_SEC_SEND
                     && secp == media_fmt_pkg::SECP_DEVICE) begin
            sec_valid_q <= 1'b1;
            sec_proto_q <= secp;
            sec_data_q <= cdw11_q;
        end else if (cmd_go && cmd_op == media_fmt_pkg::OP_SEC_RECV) begin
            if (secp == media_fmt_pkg::SECP_DISCOVERY) begin
                // discovery is not tied to any send
                sec_rdata_q <= media_fmt_pkg::SEC_DISC_WORD;
            end else if (sec_valid_q && secp == sec_proto_q) begin
                sec_rdata_q <= sec_data_q;
                sec_valid_q <= 1'b0;
            end else begin
                sec_rdata_q <= media_fmt_pkg::RST_WORD;
            end
        end
    end

    // ========================================
    // completion entry; a pop in the same cycle as a new post loses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpl_valid_q <= 1'b0;
            cpl_status_q <= media_fmt_pkg::SC_SUCCESS;
            cpl_op_q <= 8'h00;
        end else if (fmt_done) begin
            // format posts only from the engine's done
            cpl_valid_q <= 1'b1;
            cpl_status_q <= fmt_status;
            cpl_op_q <= media_fmt_pkg::OP_FORMAT;
        end else if (cmd_go && cmd_op != media_fmt_pkg::OP_FORMAT) begin
            cpl_valid_q <= 1'b1;
            cpl_op_q <= cmd_op;
            case (cmd_op)
                media_fmt_pkg::OP_SEC_SEND,
                media_fmt_pkg::OP_SEC_RECV: begin
                    // only the device protocol, and discovery on a receive, are supported
                    if (secp == media_fmt_pkg::SECP_DEVICE
                        || (secp == media_fmt_pkg::SECP_DISCOVERY
                            && cmd_op == media_fmt_pkg::OP_SEC_RECV)) begin
                        cpl_status_q <= media_fmt_pkg::SC_SUCCESS;
                    end else begin
                        cpl_status_q <= media_fmt_pkg::SC_INVALID_FIELD;
                    end
                end
                default: cpl_status_q <= media_fmt_pkg::SC_INVALID_OPCODE;
            endcase
        end else if (wr_en && paddr == media_fmt_pkg::OFF_CPL) begin
            cpl_valid_q <= 1'b0;
        end
    end

    // ========================================
    // read mux, latched in the setup phase so prdata is a flop at access
    always_comb begin
        rd_d = 32'h0000_0000;
        case (paddr)
            media_fmt_pkg::OFF_CDW10: rd_d = cdw10_q;
            media_fmt_pkg::OFF_CDW11: rd_d = cdw11_q;
            media_fmt_pkg::OFF_STATUS: begin
                rd_d[media_fmt_pkg::STAT_BUSY_BIT] = fmt_busy || fmt_start_q;
                rd_d[media_fmt_pkg::STAT_CPL_BIT] = cpl_valid_q;
                rd_d[media_fmt_pkg::STAT_SEC_BIT] = sec_valid_q;
                rd_d[media_fmt_pkg::STAT_LOCK_BIT] = sec_locked_q;
            end
            media_fmt_pkg::OFF_CPL: begin
                rd_d[7:0] = cpl_status_q;
                rd_d[media_fmt_pkg::CPL_OP_LSB +: 8] = cpl_op_q;
                rd_d[media_fmt_pkg::CPL_VALID_BIT] = cpl_valid_q;
            end
            media_fmt_pkg::OFF_FMT: begin
                rd_d[2:0] = prot_type;
                rd_d[media_fmt_pkg::FMT_INLINE_BIT] = inline_on;
                rd_d[media_fmt_pkg::FMT_IDX_LSB +: 4] = fmt_index;
                rd_d[media_fmt_pkg::FMT_FIRST_BIT] = prot_first;
                rd_d[media_fmt_pkg::FMT_OFF_LSB +: 8] = prot_offset;
            end
            media_fmt_pkg::OFF_CTRL: rd_d[media_fmt_pkg::CTRL_LOCK_BIT] = sec_locked_q;
            media_fmt_pkg::OFF_FMT_TABLE: begin
                rd_d[3:0] = table_sel_q;
                rd_d[media_fmt_pkg::TABLE_SUP_BIT] = fmt_sup_q[table_sel_q];
                rd_d[media_fmt_pkg::TABLE_MD_LSB +: 8] = fmt_md_q[table_sel_q];
            end
            media_fmt_pkg::OFF_RDATA: rd_d = sec_rdata_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= media_fmt_pkg::RST_WORD;
        end else if (rd_setup) begin
            prdata_q <= rd_d;
        end
    end

    // ========================================
    // checks
    sequence s_recv_match;
        cmd_go && cmd_op == 8'h82 && sec_valid_q && secp == sec_proto_q && !sec_drop;
    endsequence
    property p_recv_data;
        @(posedge pclk) disable iff (!presetn)
        s_recv_match |=> (sec_rdata_q == $past(sec_data_q) && !sec_valid_q && cpl_valid_q
            && cpl_status_q == 8'h00);
    endproperty
    a_recv_data: assert property (p_recv_data) else $error("receive lost send result");
    property p_drop;
        @(posedge pclk) disable iff (!presetn)
        sec_drop |=> !sec_valid_q;
    endproperty
    a_drop: assert property (p_drop) else $error("result survived reset");
    property p_fmt_post;
        @(posedge pclk) disable iff (!presetn)
        $rose(cpl_valid_q) && cpl_op_q == 8'h80 |-> $past(fmt_done) && !fmt_busy;
    endproperty
    a_fmt_post: assert property (p_fmt_post) else $error("format posted early");
endmodule : media_format_sec_rx
`default_nettype wire

// File: bench/host_model.sv
// host model: apb master issuing admin commands
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int hung = 0; // transfers that never saw pready
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // call just after an edge; the request holds until pready is sampled high, for at most 20 more edges
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] re);
        int n;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge pclk);
        if (pready !== 1'b1) hung++;
        re = {pslverr, prdata};
        // released lines flip so a stale address or data cannot pass
        {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
        @(posedge pclk);
    endtask : xfer
endmodule : host_model
`default_nettype wire

// File: bench/tb.sv
// self-checking bench: format and security receive commands over apb
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [32:0] r; // pslverr and read data of the last transfer
    int num_errors = 0, num_checks = 0;
    initial forever #5 pclk = ~pclk; // 100 mhz
    media_format_sec_rx media_format_sec_rx_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    host_model host_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ========================================
    // compare, verdict and bus access
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) num_errors++;
        if (got !== exp) $display("mismatch at %0t got %h exp %h", $time, got, exp);
    endtask : chk
    task tally_and_finish;
        num_errors += host_model_inst.hung;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    // a hung bus ends the run at once
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        host_model_inst.xfer(w, a, d, r);
        if (host_model_inst.hung > 0) tally_and_finish();
    endtask : acc
    // issue a command, poll its completion a bounded number of times, pop it
    task cmd(input logic [7:0] op, input logic [31:0] c10, input logic [7:0] sc);
        acc(1'b1, media_fmt_pkg::OFF_CDW10, c10);
        acc(1'b1, media_fmt_pkg::OFF_CMD, {24'h0, op});
        acc(1'b0, media_fmt_pkg::OFF_CPL, 32'h0);
        // a good format runs for many cycles, so no entry may be posted yet
        if (op == media_fmt_pkg::OP_FORMAT && sc == media_fmt_pkg::SC_SUCCESS)
            chk(r[31:0] & 32'h0001_0000, 32'h0);
        for (int n = 0; n < 40 && r[16] !== 1'b1; n++) acc(1'b0, media_fmt_pkg::OFF_CPL, 32'h0);
        chk(r[31:0], {15'h0, 1'b1, op, sc});
        acc(1'b1, media_fmt_pkg::OFF_CPL, 32'h0);
    endtask : cmd
    // entry 1 has 16 metadata bytes; rows walk protection types, rejects, a zero-metadata format, then the lock
    task t_format;
        logic [11:0] c10 [9] = '{12'h031, 12'h041, 12'h161, 12'h081, 12'h0E1,
            12'h020, 12'h005, 12'h010, 12'h031};
        logic [19:0] fmt [9] = '{20'h80019, 20'h80012, 20'h00113, 20'h00113, 20'h00113,
            20'h00113, 20'h00113, 20'h00000, 20'h00000};
        logic [8:0] bad = 9'h178; // rows that must be refused
        acc(1'b1, media_fmt_pkg::OFF_FMT_TABLE, 32'h0000_1011);
        for (int i = 0; i < 9; i++) begin
            acc(1'b1, media_fmt_pkg::OFF_CTRL, {31'h0, i == 8}); // lock only on the last row
            cmd(media_fmt_pkg::OP_FORMAT, {20'h0, c10[i]}, bad[i] ?
                media_fmt_pkg::SC_INVALID_FORMAT : media_fmt_pkg::SC_SUCCESS);
            acc(1'b0, media_fmt_pkg::OFF_FMT, 32'h0);
            chk(r[31:0], {12'h0, fmt[i]});
        end
    endtask : t_format
    // a stored send result returns on the next receive; an unmapped read is refused
    task t_security;
        acc(1'b1, media_fmt_pkg::OFF_CDW11, 32'h1234_ABCD);
        cmd(media_fmt_pkg::OP_SEC_SEND, 32'hEA00_0000, media_fmt_pkg::SC_SUCCESS);
        cmd(media_fmt_pkg::OP_SEC_RECV, 32'hEA00_0000, media_fmt_pkg::SC_SUCCESS);
        acc(1'b0, media_fmt_pkg::OFF_RDATA, 32'h0);
        chk(r[31:0], 32'h1234_ABCD);
        acc(1'b0, 8'h40, 32'h0);
        chk({31'h0, r[32]}, 32'h1);
        // a link loss drops a pending result; the next device receive finds nothing
        cmd(media_fmt_pkg::OP_SEC_SEND, 32'hEA00_0000, media_fmt_pkg::SC_SUCCESS);
        acc(1'b1, media_fmt_pkg::OFF_CTRL, 32'h0000_0004);
        acc(1'b0, media_fmt_pkg::OFF_STATUS, 32'h0);
        chk(r[31:0], 32'h0);
        cmd(media_fmt_pkg::OP_SEC_RECV, 32'hEA00_0000, media_fmt_pkg::SC_SUCCESS);
        acc(1'b0, media_fmt_pkg::OFF_RDATA, 32'h0);
        chk(r[31:0], 32'h0);
        cmd(media_fmt_pkg::OP_SEC_RECV, 32'h0, media_fmt_pkg::SC_SUCCESS);
        acc(1'b0, media_fmt_pkg::OFF_RDATA, 32'h0);
        chk(r[31:0], media_fmt_pkg::SEC_DISC_WORD);
        cmd(media_fmt_pkg::OP_SEC_RECV, 32'h0100_0000, media_fmt_pkg::SC_INVALID_FIELD);
        cmd(8'h7F, 32'h0, media_fmt_pkg::SC_INVALID_OPCODE);
    endtask : t_security
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_format();
        t_security();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
